// ---- rtl/scs_consts.vh ----
// constants of the system clock source select block
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH
// register offsets
`define SCS_OFF_SYS_CFG 8'h00
`define SCS_OFF_PLL_CFG 8'h04
`define SCS_OFF_PRESCALE 8'h08
`define SCS_OFF_MEM_CFG 8'h0c
`define SCS_OFF_STATUS 8'h10
// system_clock_config fields
`define SCS_SRC_LSB 0
`define SCS_SRC_MSB 1
// pll_config fields
`define SCS_BYP_BIT 0
`define SCS_BAND_LSB 1
`define SCS_BAND_MSB 2
`define SCS_REF_BIT 3
`define SCS_PLL_INPUT_DIVIDER_FIELD_LSB 4
`define SCS_PLL_INPUT_DIVIDER_FIELD_MSB 7
`define SCS_PLL_MULTIPLIER_FIELD_LSB 8
`define SCS_PLL_MULTIPLIER_FIELD_MSB 14
`define SCS_K2_LSB 15
`define SCS_K2_MSB 21
// prescaler and memory startup fields
`define SCS_K1_LSB 0
`define SCS_K1_MSB 9
`define SCS_SFA_BIT 0
// source select codes
`define SCS_SRC_WAKEUP 2'h0
`define SCS_SRC_OSC 2'h2
`define SCS_SRC_DIRECT 2'h3
// vco band codes
`define SCS_BAND_LOW 2'h0
`define SCS_BAND_MID 2'h1
`define SCS_BAND_HIGH 2'h2
// reset values
`define SCS_RST_SRC 2'h0
`define SCS_RST_BYP 1'b1
`define SCS_RST_BAND 2'h0
`define SCS_RST_PLL_INPUT_DIVIDER_FIELD 4'h0
`define SCS_RST_PLL_MULTIPLIER_FIELD 7'h00
`define SCS_RST_K2 7'h00
`define SCS_RST_K1 10'h000
// multiplier ramp step time and clock rate
`define SCS_RAMP_STEP_NS 1000
`define SCS_MCLK_MHZ 200
`define SCS_RAMP_CYCLES ((`SCS_RAMP_STEP_NS * `SCS_MCLK_MHZ) / 1000)
`endif

// ---- rtl/scs_clk_div.v ----
// edge counting divider for a sampled clock level, factor is field plus one
`timescale 1ns/100ps
module scs_clk_div (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // sampled source level and factor field
    input wire src_level,
    input wire [9:0] div_field,
    // divided level
    output reg out_level
);
    reg src_prev_reg;
    reg [9:0] cnt_reg;
    reg [9:0] div_reg;
    wire rise;
    wire [10:0] half_sum;
    wire [9:0] half;

    assign rise = src_level & ~src_prev_reg;
    assign half_sum = {1'b0, div_reg} + 11'h001;
    assign half = half_sum[10:1];

    // count source rising edges, new factor only taken at a period boundary
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev_reg <= 1'b0;
            cnt_reg <= 10'h000;
            div_reg <= 10'h000;
            out_level <= 1'b0;
        end else begin
            src_prev_reg <= src_level;
            if (div_reg == 10'h000) begin
                out_level <= src_level; // factor one passes the source duty
                if (rise) begin
                    div_reg <= div_field;
                    cnt_reg <= 10'h000;
                end
            end else if (rise) begin
                if (cnt_reg == div_reg) begin
                    cnt_reg <= 10'h000;
                    div_reg <= div_field;
                    out_level <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 10'h001;
                    if (cnt_reg + 10'h001 == half) begin
                        out_level <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// ---- rtl/scs_clock_select.v ----
// system clock source selection, prescaler, pll control and switching
`timescale 1ns/100ps
`include "scs_consts.vh"
// Functional notes
// - source code 11 drives system clock straight from external clock input one
// - code 10 with bypass set divides oscillator by the prescaler factor
// - prescaler factor equals the prescaler field plus one
// - largest prescaler factor is 1024, giving the slowest system clock
// - factor one passes the oscillator unchanged, keeping its duty cycle
// - crystal bypass with factor one acts like direct drive
// - code 10 with bypass clear enables the pll and uses its clock
// - pll factor is N over P times K2, each field plus one
// - pll reference comes from crystal input or internal clock source
// - pll system clock is the vco clock divided by K2
// - pll approaches a new multiplier gradually, never abruptly
// - vco band field: 00 low, 01 middle, 10 high band
// - source code 00 runs the system clock from the wakeup clock
module scs_clock_select (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata,
    // clock source pins, asynchronous to mclk
    input wire external_clock_input_one,
    input wire crystal_input,
    input wire internal_clk_in,
    input wire wakeup_clk_in,
    input wire vco_clk_in,
    // system clock out
    output reg sys_clk,
    // analog pll control
    output reg pll_enable,
    output reg pll_ref_internal,
    output reg [1:0] pll_band,
    output reg [3:0] pll_input_div,
    output reg [6:0] pll_mult,
    // memory startup control
    output reg flash_safe_access
);
    // path one-hot codes
    localparam [3:0] PATH_WU = 4'h1;
    localparam [3:0] PATH_PRE = 4'h2;
    localparam [3:0] PATH_PLL = 4'h4;
    localparam [3:0] PATH_EXT = 4'h8;
    // switch states
    localparam [2:0] ST_RUN = 3'h1;
    localparam [2:0] ST_DRAIN = 3'h2;
    localparam [2:0] ST_ARM = 3'h4;
    localparam integer RAMP_LAST_I = `SCS_RAMP_CYCLES - 1;
    localparam [15:0] RAMP_LAST = RAMP_LAST_I[15:0];

    // map source field and bypass bit onto a clock path
    function [3:0] path_of;
        input [1:0] src;
        input byp;
        begin
            case (src)
                `SCS_SRC_DIRECT: path_of = PATH_EXT;
                `SCS_SRC_OSC: path_of = byp ? PATH_PRE : PATH_PLL;
                `SCS_SRC_WAKEUP: path_of = PATH_WU;
                default: path_of = PATH_WU;
            endcase
        end
    endfunction

    // pick the level of one path
    function level_of;
        input [3:0] path;
        input [3:0] levels;
        begin
            level_of = |(path & levels);
        end
    endfunction

    // reset release
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_s_n;
    // configuration registers
    reg [1:0] src_sel_reg;
    reg vco_bypass_reg;
    reg [1:0] vco_band_select_reg;
    reg ref_internal_reg;
    reg [3:0] pll_input_divider_field_reg;
    reg [6:0] pll_multiplier_field_reg;
    reg [6:0] pll_output_divider_field_reg;
    reg [9:0] prescaler_divider_field_reg;
    reg flash_safe_access_bit_reg;
    // pin synchronisers, first and second stage
    reg [4:0] pin_meta_reg;
    reg [4:0] pin_sync_reg;
    // switch control
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [3:0] path_reg;
    reg [3:0] path_next;
    reg sys_next;
    reg [15:0] ramp_cnt_reg;
    wire [3:0] want_path;
    wire [3:0] levels;
    wire cur_level;
    wire osc_level;
    wire pre_level;
    wire pll_level;
    wire ext_level;
    wire wu_level;
    wire vco_level;
    wire ramp_tick;
    wire pll_locked;
    wire [6:0] mult_target;
    // reference mux control
    reg ref_used_reg;
    reg osc_prev_reg;
    wire new_ref_level;
    wire ref_swap;

    // two stage reset release, asynchronous assertion
    // every other process uses the released copy, so leaving reset is always synchronous
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_s_n = rst_sync_reg;

    // two flip-flop sampling of every source pin
    // pins must toggle slower than half the mclk rate to be sampled faithfully
    always @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end else begin
            pin_meta_reg <= {vco_clk_in, wakeup_clk_in, internal_clk_in, crystal_input,
                external_clock_input_one};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign ext_level = pin_sync_reg[0];
    assign wu_level = pin_sync_reg[3];
    assign vco_level = pin_sync_reg[4];
    // level of the requested reference, and the swap moment: the level in use has been
    // low for two samples and the requested one is low too, so no runt reaches a divider
    assign new_ref_level = ref_internal_reg ? pin_sync_reg[2] : pin_sync_reg[1];
    assign ref_swap = (ref_used_reg != ref_internal_reg) && !osc_level && !osc_prev_reg &&
        !new_ref_level;
    // oscillator from crystal input or internal source, through the applied selection
    assign osc_level = ref_used_reg ? pin_sync_reg[2] : pin_sync_reg[1];

    // applied reference selection follows the register only at a swap moment
    always @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ref_used_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_level;
            if (ref_swap) begin
                ref_used_reg <= ref_internal_reg;
            end
        end
    end

    // register writes
    // a write lands at its strobe edge; unmapped offsets are ignored
    always @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            src_sel_reg <= `SCS_RST_SRC;
            vco_bypass_reg <= `SCS_RST_BYP;
            vco_band_select_reg <= `SCS_RST_BAND;
            ref_internal_reg <= 1'b0;
            pll_input_divider_field_reg <= `SCS_RST_PLL_INPUT_DIVIDER_FIELD;
            pll_multiplier_field_reg <= `SCS_RST_PLL_MULTIPLIER_FIELD;
            pll_output_divider_field_reg <= `SCS_RST_K2;
            prescaler_divider_field_reg <= `SCS_RST_K1;
            flash_safe_access_bit_reg <= 1'b0;
        end else if (wr_stb) begin
            case (addr)
                `SCS_OFF_SYS_CFG: begin
                    src_sel_reg <= wdata[`SCS_SRC_MSB:`SCS_SRC_LSB];
                end
                `SCS_OFF_PLL_CFG: begin
                    vco_bypass_reg <= wdata[`SCS_BYP_BIT];
                    vco_band_select_reg <= wdata[`SCS_BAND_MSB:`SCS_BAND_LSB];
                    ref_internal_reg <= wdata[`SCS_REF_BIT];
                    pll_input_divider_field_reg <= wdata[`SCS_PLL_INPUT_DIVIDER_FIELD_MSB:`SCS_PLL_INPUT_DIVIDER_FIELD_LSB];
                    pll_multiplier_field_reg <= wdata[`SCS_PLL_MULTIPLIER_FIELD_MSB:`SCS_PLL_MULTIPLIER_FIELD_LSB];
                    pll_output_divider_field_reg <= wdata[`SCS_K2_MSB:`SCS_K2_LSB];
                end
                `SCS_OFF_PRESCALE: begin
                    prescaler_divider_field_reg <= wdata[`SCS_K1_MSB:`SCS_K1_LSB];
                end
                `SCS_OFF_MEM_CFG: begin
                    flash_safe_access_bit_reg <= wdata[`SCS_SFA_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // read data, valid the cycle after the strobe, unmapped reads give zero
    // status is a live view of the switch, the path and the lock
    always @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rdata <= 32'h00000000;
        end else if (rd_stb) begin
            case (addr)
                `SCS_OFF_SYS_CFG: rdata <= {30'h00000000, src_sel_reg};
                `SCS_OFF_PLL_CFG: rdata <= {10'h000, pll_output_divider_field_reg,
                    pll_multiplier_field_reg, pll_input_divider_field_reg,
                    ref_internal_reg, vco_band_select_reg, vco_bypass_reg};
                `SCS_OFF_PRESCALE: rdata <= {22'h000000, prescaler_divider_field_reg};
                `SCS_OFF_MEM_CFG: rdata <= {31'h00000000, flash_safe_access_bit_reg};
                `SCS_OFF_STATUS: rdata <= {24'h000000, pll_locked, state_reg[0], path_reg,
                    sys_clk, pll_enable};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // prescaler on the oscillator, factor field plus one
    // factor changes wait for a period boundary inside the divider
    scs_clk_div u_prescaler (
        .clk(mclk),
        .rst_n(rst_s_n),
        .src_level(osc_level),
        .div_field(prescaler_divider_field_reg),
        .out_level(pre_level)
    );

    // output divider K2 on the vco clock
    scs_clk_div u_out_div (
        .clk(mclk),
        .rst_n(rst_s_n),
        .src_level(vco_level),
        .div_field({3'h0, pll_output_divider_field_reg}),
        .out_level(pll_level)
    );

    assign levels = {ext_level, pll_level, pre_level, wu_level};
    assign want_path = path_of(src_sel_reg, vco_bypass_reg);
    assign cur_level = level_of(path_reg, levels);

    // glitch free switch: finish the high phase, park low, join new source low
    // a high phase is never cut, and the output parks low for at least two samples
    always @* begin
        state_next = state_reg;
        path_next = path_reg;
        sys_next = sys_clk;
        case (state_reg)
            ST_RUN: begin
                sys_next = cur_level;
                if (want_path != path_reg) begin
                    state_next = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                sys_next = cur_level;
                if (!cur_level) begin
                    sys_next = 1'b0;
                    path_next = want_path;
                    state_next = ST_ARM;
                end
            end
            ST_ARM: begin
                sys_next = 1'b0;
                if (!cur_level) begin
                    state_next = ST_RUN; // next rise of the new source is whole
                end
            end
            default: begin
                state_next = ST_RUN;
                sys_next = 1'b0;
            end
        endcase
    end

    // switch state and system clock level
    always @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_reg <= ST_ARM;
            path_reg <= PATH_WU;
            sys_clk <= 1'b0;
        end else begin
            state_reg <= state_next;
            path_reg <= path_next;
            sys_clk <= sys_next;
        end
    end

    // ramp step timer for the multiplier
    // one multiplier step per tick keeps the vco from jumping
    assign ramp_tick = (ramp_cnt_reg == RAMP_LAST);
    always @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ramp_cnt_reg <= 16'h0000;
        end else if (ramp_tick) begin
            ramp_cnt_reg <= 16'h0000;
        end else begin
            ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
        end
    end

    // the multiplier walks down to its start value while the pll is off, so an enable
    // that comes after it gets there begins a fresh gradual approach
    assign mult_target = pll_enable ? pll_multiplier_field_reg : `SCS_RST_PLL_MULTIPLIER_FIELD;
    assign pll_locked = pll_enable && (pll_mult == pll_multiplier_field_reg);

    // pll control: enable, reference, band, input divider, stepped multiplier
    // the analog side sees only registered copies of the fields
    always @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pll_enable <= 1'b0;
            pll_ref_internal <= 1'b0;
            pll_band <= `SCS_RST_BAND;
            pll_input_div <= `SCS_RST_PLL_INPUT_DIVIDER_FIELD;
            pll_mult <= `SCS_RST_PLL_MULTIPLIER_FIELD;
            flash_safe_access <= 1'b0;
        end else begin
            pll_enable <= (want_path == PATH_PLL) || (path_reg == PATH_PLL);
            pll_ref_internal <= ref_internal_reg;
            pll_band <= vco_band_select_reg;
            pll_input_div <= pll_input_divider_field_reg;
            flash_safe_access <= flash_safe_access_bit_reg;
            if (ramp_tick) begin
                if (pll_mult < mult_target) begin
                    pll_mult <= pll_mult + 7'h01;
                end else if (pll_mult > mult_target) begin
                    pll_mult <= pll_mult - 7'h01;
                end
            end
        end
    end
endmodule

// ---- sim/scs_clock_select_chk.sv ----
// assertion checker for the system clock source select block
`timescale 1ns/100ps
module scs_chk (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [31:0] rdata,
    // source pins
    input wire external_clock_input_one,
    input wire wakeup_clk_in,
    // outputs
    input wire sys_clk,
    input wire pll_enable,
    input wire pll_ref_internal,
    input wire [1:0] pll_band,
    input wire [3:0] pll_input_div,
    input wire [6:0] pll_mult
);
    logic [1:0] src_reg;
    logic [21:0] pll_reg;
    logic [7:0] quiet_reg;
    logic settled;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // shadow of the written mode fields and cycles since the last mode write
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= 2'h0;
            pll_reg <= 22'h000001;
            quiet_reg <= 8'h00;
        end else begin
            if (wr_stb && addr == 8'h00) src_reg <= wdata[1:0];
            if (wr_stb && addr == 8'h04) pll_reg <= wdata[21:0];
            if (wr_stb && addr <= 8'h08) quiet_reg <= 8'h00;
            else if (quiet_reg != 8'hff) quiet_reg <= quiet_reg + 8'h01;
        end
    end
    // switching drains within this many cycles for the pin rates in use
    assign settled = quiet_reg >= 8'd120;
    sequence s_step;
        $changed(pll_mult);
    endsequence
    sequence s_hold;
        $stable(pll_mult) [*8];
    endsequence
    a_rdata_idle: assert property (
        !$past(rd_stb) |-> rdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    a_direct_follow: assert property (
        settled && src_reg == 2'h3 |-> sys_clk == $past(external_clock_input_one, 3))
        else $error("system clock does not track the direct pin");
    a_wakeup_follow: assert property (
        settled && !src_reg[1] |-> sys_clk == $past(wakeup_clk_in, 3))
        else $error("system clock does not track the wakeup clock");
    a_pll_on: assert property (
        settled |-> pll_enable == (src_reg == 2'h2 && !pll_reg[0]))
        else $error("pll enable does not match the mode");
    a_pll_fields: assert property (
        settled |-> {pll_ref_internal, pll_input_div, pll_band}
            == {pll_reg[3], pll_reg[7:4], pll_reg[2:1]})
        else $error("pll band, divider or reference wrong");
    a_mult_step: assert property (
        s_step |-> pll_mult == $past(pll_mult) + 7'h1 || pll_mult == $past(pll_mult) - 7'h1)
        else $error("multiplier moved by more than one");
    a_mult_dwell: assert property (
        s_step |=> s_hold)
        else $error("multiplier stepped too soon");
    a_no_runt_high: assert property (
        $rose(sys_clk) |=> sys_clk)
        else $error("short high pulse on system clock");
    a_no_runt_low: assert property (
        $fell(sys_clk) |=> !sys_clk)
        else $error("short low pulse on system clock");
endmodule

// ---- sim/system_clock_source_select_tb.sv ----
// self-checking testbench for the system clock source select block
`timescale 1ns/100ps
module system_clock_source_select_tb;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg ext_pin = 1'b0, xtal = 1'b0, int_clk = 1'b0, wu_clk = 1'b0, vco = 1'b0, pv = 1'b0;
    wire [31:0] rdata;
    wire sys_clk, pll_enable, pll_ref_internal, flash_safe_access;
    wire [1:0] pll_band;
    wire [3:0] pll_input_div;
    wire [6:0] pll_mult;
    integer fail_count = 0, compares = 0, cyc = 0, seed = 32'ha7c0a269;
    integer mdl [0:3];
    integer i, n, hi, e;
    reg [31:0] d, q;
    reg [7:0] a;
    always #2.5 mclk = ~mclk;
    // source pins at fixed slow rates, plus the run limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        ext_pin <= (cyc / 4) % 2 == 1;
        xtal <= (cyc / 3) % 2 == 1;
        int_clk <= (cyc / 5) % 2 == 1;
        wu_clk <= (cyc / 10) % 2 == 1;
        vco <= (cyc / 3) % 2 == 1;
        if (cyc == 40000) begin
            fail_count = fail_count + 1;
            end_sim;
        end
    end
    scs_clock_select dut (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .external_clock_input_one(ext_pin),
        .crystal_input(xtal), .internal_clk_in(int_clk), .wakeup_clk_in(wu_clk),
        .vco_clk_in(vco), .sys_clk(sys_clk), .pll_enable(pll_enable),
        .pll_ref_internal(pll_ref_internal), .pll_band(pll_band),
        .pll_input_div(pll_input_div), .pll_mult(pll_mult),
        .flash_safe_access(flash_safe_access)
    );
    // compare and count
    task check(input [31:0] seen, input [31:0] exp, input [8*8:1] nm);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // register write, one strobe cycle
    task wr(input [7:0] ad, input [31:0] v);
        begin
            addr <= ad;
            wdata <= v;
            wr_stb <= 1'b1;
            @(posedge mclk);
            wr_stb <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // register read, data taken in the answer cycle
    task rd(input [7:0] ad);
        begin
            addr <= ad;
            rd_stb <= 1'b1;
            @(posedge mclk);
            rd_stb <= 1'b0;
            #1;
            q = rdata;
            @(posedge mclk);
        end
    endtask
    // count system clock rises and high cycles over w cycles, compare rises
    task count(input integer w, input integer ex);
        begin
            n = 0;
            hi = 0;
            repeat (w) begin
                @(posedge mclk);
                #1;
                if (sys_clk === 1'b1 && pv === 1'b0) n = n + 1;
                if (sys_clk === 1'b1) hi = hi + 1;
                pv = sys_clk;
            end
            check({31'h0, n >= ex - 1 && n <= ex + 1}, 32'h1, "rises");
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    initial begin
        mdl[0] = 0;
        mdl[1] = 1;
        mdl[2] = 0;
        mdl[3] = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        // reset values, and the status view: wakeup path, switch running
        for (i = 0; i < 5; i = i + 1) begin
            rd({i[5:0], 2'b00});
            check((i < 4) ? q : q & 32'hfd, (i < 4) ? mdl[i] : 32'h44, "reset");
        end
        $display("reset test done");
        // random pll settings, safe access bit and unmapped writes, read back
        for (i = 0; i < 12; i = i + 1) begin
            n = {$random(seed)} % 3;
            d = $random(seed) & 32'hffff83ff;
            a = 8'h04 + {n[4:0], 3'b000};
            wr(a, d);
            if (n == 0) mdl[1] = d & 32'h3fffff;
            if (n == 1) mdl[3] = d & 1;
            rd(a);
            check(q, (n == 2) ? 0 : mdl[a / 4], "rdback");
            check({pll_ref_internal, pll_input_div, pll_band, flash_safe_access, pll_enable},
                {mdl[1][3], mdl[1][7:4], mdl[1][2:1], mdl[3][0], 1'b0}, "outs");
        end
        $display("register test done");
        // every source code: status path and system clock rate
        wr(8'h04, 32'h1);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h00, (i == 0) ? 1 : (i == 1) ? 0 : (i == 2) ? 3 : 2);
            repeat (60) @(posedge mclk);
            rd(8'h10);
            e = (i < 2) ? 1 : (i == 2) ? 8 : 2;
            check(q & 32'h3d, e << 2, "path");
            count(240, (i < 2) ? 12 : (i == 2) ? 30 : 40);
        end
        check({31'h0, hi >= 117 && hi <= 123}, 32'h1, "duty");
        $display("source test done");
        // prescaler from the internal source, then factor three
        wr(8'h04, 32'h9);
        repeat (40) @(posedge mclk);
        count(240, 24);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h2);
        repeat (40) @(posedge mclk);
        count(360, 20);
        $display("prescaler test done");
        // pll: band 2, P 2, N 4, K2 2 from the crystal
        wr(8'h08, 32'h0);
        wr(8'h0c, 32'h1);
        wr(8'h04, 32'h8314);
        check(flash_safe_access, 1'b1, "safe");
        for (i = 0; i < 2000 && pll_mult !== 7'h3; i = i + 1) @(posedge mclk);
        check(pll_mult, 7'h3, "mult");
        check(pll_enable, 1'b1, "pll_on");
        check({pll_band, pll_input_div}, 6'h21, "band");
        rd(8'h10);
        check(q & 32'hbd, 32'h91, "locked");
        count(240, 20);
        $display("pll test done");
        // largest prescaler factor
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h3ff);
        repeat (40) @(posedge mclk);
        count(24576, 4);
        check(pll_enable, 1'b0, "pll_off");
        $display("slowest clock test done");
        end_sim;
    end
endmodule
bind scs_clock_select scs_chk u_chk (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .external_clock_input_one(external_clock_input_one),
    .wakeup_clk_in(wakeup_clk_in), .sys_clk(sys_clk), .pll_enable(pll_enable),
    .pll_ref_internal(pll_ref_internal), .pll_band(pll_band),
    .pll_input_div(pll_input_div), .pll_mult(pll_mult)
);
